// ===== core/usfb_device.sv
// usart device end: i/o registers, baud prescaler, framing transmitter and receiver
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module usfb_device
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// cpu i/o port
	input wire logic [5:0] io_addr,
	input wire logic io_we,
	input wire logic io_re,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	// interrupt
	input wire logic cpu_status_word_gie,
	output logic irq_buffer_empty,
	// general-purpose port functions of the pins
	input wire logic port_tx_level,
	input wire logic port_tx_oe,
	output logic port_rx_level,
	// serial link
	usfb_link_if.device link
);
	localparam int W = usfb_pkg::FRAME_W;

	logic [7:0] ctrl_b_r; // enables, size high bit, transmit ninth bit
	logic [6:0] ctrl_c_r; // mode, parity, stop, size low bits, polarity
	logic [3:0] baud_hi_r; // divider bits 11:8
	logic [7:0] baud_lo_r; // divider bits 7:0
	logic [usfb_pkg::DIV_W-1:0] presc_r; // prescaler down counter
	logic shared_rd_r; // last read or write access was a read of the shared location
	logic xck_r; // synchronous clock level
	logic [W-1:0] tx_sh_r; // transmit shifter, bit 0 on the pin
	logic [3:0] tx_left_r; // bits still to send including current
	logic [8:0] tx_buf_r; // transmit buffer
	logic tx_full_r; // transmit buffer holds data
	logic txc_r; // transmit complete flag
	logic [W-1:0] rx_sh_r; // receive shifter, fills from the top
	logic [3:0] rx_left_r; // bits still to sample
	logic [usfb_pkg::DIV_W-1:0] rx_cnt_r; // asynchronous bit timer
	logic rx_done_r; // frame just completed
	logic [8:0] rx_buf_r; // receive buffer
	logic rx_full_r; // receive buffer holds unread data
	logic fe_r; // frame error of buffered character
	logic pe_r; // parity error of buffered character
	logic dor_r; // overrun

	logic [usfb_pkg::DIV_W-1:0] divider; // full divider value
	logic baud_tick; // prescaler wrap
	logic sync_mode; // synchronous operation selected
	logic [3:0] nbits; // data bits per character
	logic [3:0] tx_len; // transmit frame length
	logic [3:0] rx_len; // receive frame length, one stop
	logic xck_drive_ev; // synchronous edge on which transmit data changes
	logic xck_samp_ev; // synchronous edge on which receive data is sampled
	logic tx_ev; // transmit shift moment
	logic rx_ev; // receive sample moment
	logic tx_active; // transmitter owns the pin
	logic rxd; // receive pin level
	logic wr_data; // cpu writes data register
	logic rd_data; // cpu reads data register
	logic [W-1:0] rx_aligned; // received frame, start bit at bit 0

	assign divider = {baud_hi_r, baud_lo_r};
	assign baud_tick = (presc_r == '0);
	assign sync_mode = ctrl_c_r[usfb_pkg::C_SYNC];
	assign nbits = usfb_pkg::char_bits({ctrl_b_r[usfb_pkg::B_CSZ_HI], ctrl_c_r[usfb_pkg::C_CSZ_MID],
		ctrl_c_r[usfb_pkg::C_CSZ_LO]});
	assign tx_len = usfb_pkg::frame_len(nbits, ctrl_c_r[usfb_pkg::C_PAR_EN], ctrl_c_r[usfb_pkg::C_STOP2]);
	assign rx_len = usfb_pkg::frame_len(nbits, ctrl_c_r[usfb_pkg::C_PAR_EN], 1'b0);
	// polarity zero: transmit on rising, sample on falling; one reverses both
	assign xck_drive_ev = sync_mode && baud_tick && (xck_r == ctrl_c_r[usfb_pkg::C_POL]);
	assign xck_samp_ev = sync_mode && baud_tick && (xck_r != ctrl_c_r[usfb_pkg::C_POL]);
	assign tx_ev = sync_mode ? xck_drive_ev : baud_tick;
	assign rx_ev = sync_mode ? xck_samp_ev : (rx_left_r != 4'h0 && rx_cnt_r == '0);
	assign tx_active = ctrl_b_r[usfb_pkg::B_TX_EN] || tx_left_r != 4'h0 || tx_full_r;
	assign rxd = link.peer_txd;
	assign wr_data = io_we && io_addr == usfb_pkg::IO_DATA;
	assign rd_data = io_re && io_addr == usfb_pkg::IO_DATA;
	assign rx_aligned = rx_sh_r >> (4'(W) - rx_len);

	// pin ownership between serial logic and port functions
	assign link.dev_txd = tx_active ? tx_sh_r[0] : port_tx_level;
	assign link.dev_txd_oe = tx_active ? 1'b1 : port_tx_oe;
	assign port_rx_level = ctrl_b_r[usfb_pkg::B_RX_EN] ? 1'b1 : rxd;
	assign link.sync_serial_clock = xck_r;
	assign link.xck_oe = sync_mode && (tx_active || ctrl_b_r[usfb_pkg::B_RX_EN]);
	assign irq_buffer_empty = ctrl_b_r[usfb_pkg::B_IRQ_EN] && cpu_status_word_gie && !tx_full_r;

	// control register b, all writable bits
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ctrl_b_r <= usfb_pkg::CTRL_B_RST;
		else if (io_we && io_addr == usfb_pkg::IO_CTRL_B)
			ctrl_b_r <= io_wdata;
	end

	// shared location: bit 7 of the written value steers the write
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctrl_c_r <= usfb_pkg::CTRL_C_RST;
			baud_hi_r <= usfb_pkg::BAUD_HI_RST;
		end
		else if (io_we && io_addr == usfb_pkg::IO_SHARED)
		begin
			if (io_wdata[usfb_pkg::C_SEL])
				ctrl_c_r <= io_wdata[6:0];
			else
				baud_hi_r <= io_wdata[3:0];
		end
	end

	// baud low byte
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			baud_lo_r <= usfb_pkg::BAUD_LO_RST;
		else if (io_we && io_addr == usfb_pkg::IO_BAUD_LOW)
			baud_lo_r <= io_wdata;
	end

	// prescaler counts down, reloads on wrap or on a low byte write
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			presc_r <= '0;
		else if (io_we && io_addr == usfb_pkg::IO_BAUD_LOW)
			presc_r <= {baud_hi_r, io_wdata};
		else if (baud_tick)
			presc_r <= divider;
		else
			presc_r <= presc_r - 1'b1;
	end

	// synchronous clock toggles on every tick in synchronous mode
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			xck_r <= 1'b0;
		else if (sync_mode && baud_tick)
			xck_r <= !xck_r;
	end

	// transmit buffer: writes only land when empty and enabled
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_full_r <= 1'b0;
			tx_buf_r <= '0;
		end
		else if (wr_data && !tx_full_r && ctrl_b_r[usfb_pkg::B_TX_EN])
		begin
			tx_full_r <= 1'b1;
			tx_buf_r <= {ctrl_b_r[usfb_pkg::B_TX_NINTH], io_wdata};
		end
		else if (tx_ev && tx_left_r <= 4'h1 && tx_full_r)
			tx_full_r <= 1'b0;
	end

	// transmit shifter: loads from the buffer when the last bit ends
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_sh_r <= '1;
			tx_left_r <= 4'h0;
		end
		else if (tx_ev)
		begin
			if (tx_left_r > 4'h1)
			begin
				tx_sh_r <= {1'b1, tx_sh_r[W-1:1]};
				tx_left_r <= tx_left_r - 4'h1;
			end
			else if (tx_full_r)
			begin
				tx_sh_r <= usfb_pkg::build_frame(tx_buf_r, nbits, ctrl_c_r[usfb_pkg::C_PAR_EN],
					ctrl_c_r[usfb_pkg::C_PAR_ODD]);
				tx_left_r <= tx_len;
			end
			else
			begin
				tx_sh_r <= '1;
				tx_left_r <= 4'h0;
			end
		end
	end

	// transmit complete: set on last bit with empty buffer; writing one clears, set wins
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			txc_r <= 1'b0;
		else if (tx_ev && tx_left_r == 4'h1 && !tx_full_r)
			txc_r <= 1'b1;
		else if (io_we && io_addr == usfb_pkg::IO_STATUS_A && io_wdata[usfb_pkg::A_TXC])
			txc_r <= 1'b0;
	end

	// receiver shifter and bit timer
	always_ff @(posedge clk)
	begin
		if (sys_rst || !ctrl_b_r[usfb_pkg::B_RX_EN])
		begin
			rx_sh_r <= '1;
			rx_left_r <= 4'h0;
			rx_cnt_r <= '0;
			rx_done_r <= 1'b0;
		end
		else
		begin
			rx_done_r <= 1'b0;
			if (rx_left_r == 4'h0)
			begin
				if (!sync_mode && !rxd)
				begin
					rx_left_r <= rx_len;
					rx_cnt_r <= divider >> 1;
				end
				else if (xck_samp_ev && !rxd)
				begin
					rx_sh_r <= {rxd, rx_sh_r[W-1:1]};
					rx_left_r <= rx_len - 4'h1;
				end
			end
			else
			begin
				rx_cnt_r <= (rx_cnt_r == '0) ? divider : rx_cnt_r - 1'b1;
				if (rx_ev)
				begin
					rx_sh_r <= {rxd, rx_sh_r[W-1:1]};
					rx_left_r <= rx_left_r - 4'h1;
					rx_done_r <= (rx_left_r == 4'h1);
				end
			end
		end
	end

	// receive buffer and error flags; disable flushes all of them
	always_ff @(posedge clk)
	begin
		if (sys_rst || !ctrl_b_r[usfb_pkg::B_RX_EN])
		begin
			rx_full_r <= 1'b0;
			fe_r <= 1'b0;
			pe_r <= 1'b0;
			dor_r <= 1'b0;
			rx_buf_r <= '0;
		end
		else if (rx_done_r && rx_full_r && !rd_data)
			dor_r <= 1'b1;
		else if (rx_done_r)
		begin
			rx_full_r <= 1'b1;
			rx_buf_r <= rx_aligned[9:1] & ~(9'h1ff << nbits);
			fe_r <= !rx_aligned[rx_len - 4'h1];
			pe_r <= ctrl_c_r[usfb_pkg::C_PAR_EN] && (rx_aligned[nbits + 4'h1] !=
				usfb_pkg::parity_of(rx_aligned[9:1], nbits, ctrl_c_r[usfb_pkg::C_PAR_ODD]));
			dor_r <= 1'b0;
		end
		else if (rd_data)
		begin
			rx_full_r <= 1'b0;
			fe_r <= 1'b0;
			pe_r <= 1'b0;
			dor_r <= 1'b0;
		end
	end

	// remembers a shared read so the next one returns control c
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			shared_rd_r <= 1'b0;
		else if (io_re || io_we)
			shared_rd_r <= io_re && io_addr == usfb_pkg::IO_SHARED;
	end

	// registered read data, one cycle after the read strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			io_rdata <= '0;
		else if (io_re)
		begin
			case (io_addr)
				usfb_pkg::IO_DATA: io_rdata <= rx_buf_r[7:0];
				usfb_pkg::IO_STATUS_A: io_rdata <= {rx_full_r, txc_r, !tx_full_r, fe_r, dor_r, pe_r, 2'b00};
				usfb_pkg::IO_CTRL_B: io_rdata <= {ctrl_b_r[7:2], rx_buf_r[8], ctrl_b_r[0]};
				usfb_pkg::IO_BAUD_LOW: io_rdata <= baud_lo_r;
				usfb_pkg::IO_SHARED: io_rdata <= shared_rd_r ? {1'b1, ctrl_c_r} : {4'h0, baud_hi_r};
				default: io_rdata <= '0;
			endcase
		end
	end
endmodule

// ===== shared/usfb_pkg.sv
// shared constants, register layouts and frame helpers for the serial frame and baud control block
package usfb_pkg;
	// device i/o offsets
	localparam logic [5:0] IO_BAUD_LOW = 6'h09;
	localparam logic [5:0] IO_CTRL_B = 6'h0a;
	localparam logic [5:0] IO_STATUS_A = 6'h0b;
	localparam logic [5:0] IO_DATA = 6'h0c;
	localparam logic [5:0] IO_SHARED = 6'h20;
	// reset values
	localparam logic [6:0] CTRL_C_RST = 7'h06;
	localparam logic [7:0] CTRL_B_RST = 8'h00;
	localparam logic [3:0] BAUD_HI_RST = 4'h0;
	localparam logic [7:0] BAUD_LO_RST = 8'h00;
	// control register b bit positions
	localparam int B_IRQ_EN = 5;
	localparam int B_RX_EN = 4;
	localparam int B_TX_EN = 3;
	localparam int B_CSZ_HI = 2;
	localparam int B_RX_NINTH = 1;
	localparam int B_TX_NINTH = 0;
	// control register c bit positions
	localparam int C_SEL = 7;
	localparam int C_SYNC = 6;
	localparam int C_PAR_EN = 5;
	localparam int C_PAR_ODD = 4;
	localparam int C_STOP2 = 3;
	localparam int C_CSZ_MID = 2;
	localparam int C_CSZ_LO = 1;
	localparam int C_POL = 0;
	// status register a bit positions
	localparam int A_RXC = 7;
	localparam int A_TXC = 6;
	localparam int A_TRANSMIT_BUFFER_EMPTY_FLAG = 5;
	localparam int A_FE = 4;
	localparam int A_DOR = 3;
	localparam int A_PE = 2;
	// frame geometry
	localparam int FRAME_W = 13;
	localparam int DIV_W = 12;
	localparam logic [3:0] NINE_BITS = 4'd9;
	localparam logic [3:0] EIGHT_BITS = 4'd8;
	localparam logic [3:0] FIVE_BITS = 4'd5;
	// peer apb offsets and fields
	localparam logic [7:0] PEER_CFG = 8'h00;
	localparam logic [7:0] PEER_TX = 8'h04;
	localparam logic [7:0] PEER_RX = 8'h08;
	localparam int PC_CSZ = 12;
	localparam int PC_PAR = 15;
	localparam int PC_STOP2 = 17;
	localparam int PS_VALID = 9;
	localparam int PS_BUSY = 10;
	localparam int PS_PE = 11;
	localparam int PS_FE = 12;

	// data bits per character from the three-bit size code; reserved codes fall back to eight
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		case (code)
			3'h0, 3'h1, 3'h2, 3'h3: char_bits = FIVE_BITS + {2'h0, code[1:0]};
			3'h7: char_bits = NINE_BITS;
			default: char_bits = EIGHT_BITS;
		endcase
	endfunction

	// parity over the used data bits, inverted for odd parity
	function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n, input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++)
			if (i < n)
				p = p ^ d[i];
		parity_of = p;
	endfunction

	// bits in a frame: start, data, optional parity, one or two stops
	function automatic logic [3:0] frame_len(input logic [3:0] n, input logic par_en, input logic stop2);
		frame_len = n + 4'd2 + {3'h0, par_en} + {3'h0, stop2};
	endfunction

	// frame bits lsb first; unused upper positions idle high
	function automatic logic [FRAME_W-1:0] build_frame(input logic [8:0] d, input logic [3:0] n,
		input logic par_en, input logic odd);
		logic [FRAME_W-1:0] f;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < 9; i++)
			if (i < n)
				f[i+1] = d[i];
		for (int i = 0; i < 12; i++)
			if (par_en && i == n)
				f[i+1] = parity_of(d, n, odd);
		build_frame = f;
	endfunction
endpackage

// ===== shared/usfb_link_if.sv
// serial link between the usart device end and its remote peer
`timescale 1ns/10ps
interface usfb_link_if;
	logic dev_txd; // device transmit level
	logic dev_txd_oe; // device drives transmit pin
	logic peer_txd; // peer transmit level, device receive pin
	logic sync_serial_clock; // synchronous clock from device
	logic xck_oe; // device drives synchronous clock
	logic line_tx; // resolved transmit line, pulled high when released
	assign line_tx = dev_txd_oe ? dev_txd : 1'b1;
	modport device (output dev_txd, output dev_txd_oe, output sync_serial_clock, output xck_oe, input peer_txd);
	modport peer (input line_tx, input sync_serial_clock, input xck_oe, output peer_txd);
endinterface

// ===== core/usfb_peer.sv
// remote serial peer: asynchronous transmitter and receiver controlled over apb
`timescale 1ns/10ps
module usfb_peer
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	usfb_link_if.peer link
);
	localparam int W = usfb_pkg::FRAME_W;

	logic [17:0] cfg_r; // divider, size code, parity mode, stop select
	logic [W-1:0] tx_sh_r; // transmit shifter
	logic [3:0] tx_left_r; // bits left to send
	logic [11:0] tx_cnt_r; // transmit bit timer
	logic [W-1:0] rx_sh_r; // receive shifter
	logic [3:0] rx_left_r; // bits left to sample
	logic [11:0] rx_cnt_r; // receive bit timer
	logic [8:0] rx_data_r; // last received character
	logic rx_valid_r; // unread character present
	logic pe_r; // parity error of last character
	logic fe_r; // frame error of last character
	logic acc; // apb access phase
	logic mapped; // address decodes
	logic [3:0] nbits; // data bits per character
	logic [3:0] rx_len; // receive frame length
	logic [W-1:0] rx_frame; // completed frame aligned to bit 0
	logic rx_fin; // last bit sampled this cycle

	assign acc = psel && penable;
	assign mapped = paddr == usfb_pkg::PEER_CFG || paddr == usfb_pkg::PEER_TX || paddr == usfb_pkg::PEER_RX;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign nbits = usfb_pkg::char_bits(cfg_r[usfb_pkg::PC_CSZ +: 3]);
	assign rx_len = usfb_pkg::frame_len(nbits, cfg_r[usfb_pkg::PC_PAR + 1], 1'b0);
	assign rx_fin = rx_left_r == 4'h1 && rx_cnt_r == '0;
	assign rx_frame = {link.line_tx, rx_sh_r[W-1:1]} >> (4'(W) - rx_len);
	assign link.peer_txd = tx_sh_r[0];

	// configuration register
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cfg_r <= '0;
		else if (acc && pwrite && paddr == usfb_pkg::PEER_CFG)
			cfg_r <= pwdata[17:0];
	end

	// transmitter: a data write while idle starts a frame, otherwise ignored
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tx_sh_r <= '1;
			tx_left_r <= 4'h0;
			tx_cnt_r <= '0;
		end
		else if (tx_left_r == 4'h0)
		begin
			if (acc && pwrite && paddr == usfb_pkg::PEER_TX)
			begin
				tx_sh_r <= usfb_pkg::build_frame(pwdata[8:0], nbits, cfg_r[usfb_pkg::PC_PAR + 1],
					cfg_r[usfb_pkg::PC_PAR]);
				tx_left_r <= usfb_pkg::frame_len(nbits, cfg_r[usfb_pkg::PC_PAR + 1], cfg_r[usfb_pkg::PC_STOP2]);
				tx_cnt_r <= cfg_r[11:0];
			end
		end
		else if (tx_cnt_r == '0)
		begin
			tx_sh_r <= {1'b1, tx_sh_r[W-1:1]};
			tx_left_r <= tx_left_r - 4'h1;
			tx_cnt_r <= cfg_r[11:0];
		end
		else
			tx_cnt_r <= tx_cnt_r - 1'b1;
	end

	// receiver: start edge, then samples at mid bit
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_sh_r <= '1;
			rx_left_r <= 4'h0;
			rx_cnt_r <= '0;
		end
		else if (rx_left_r == 4'h0)
		begin
			if (!link.line_tx)
			begin
				rx_left_r <= rx_len;
				rx_cnt_r <= cfg_r[11:0] >> 1;
			end
		end
		else if (rx_cnt_r == '0)
		begin
			rx_sh_r <= {link.line_tx, rx_sh_r[W-1:1]};
			rx_left_r <= rx_left_r - 4'h1;
			rx_cnt_r <= cfg_r[11:0];
		end
		else
			rx_cnt_r <= rx_cnt_r - 1'b1;
	end

	// received character and flags; new data wins over a read in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rx_data_r <= '0;
			rx_valid_r <= 1'b0;
			pe_r <= 1'b0;
			fe_r <= 1'b0;
		end
		else if (rx_fin)
		begin
			rx_data_r <= rx_frame[9:1] & ~(9'h1ff << nbits);
			rx_valid_r <= 1'b1;
			fe_r <= !rx_frame[rx_len - 4'h1];
			pe_r <= cfg_r[usfb_pkg::PC_PAR + 1] && (rx_frame[nbits + 4'h1] !=
				usfb_pkg::parity_of(rx_frame[9:1], nbits, cfg_r[usfb_pkg::PC_PAR]));
		end
		else if (acc && !pwrite && paddr == usfb_pkg::PEER_RX)
			rx_valid_r <= 1'b0;
	end

	// read mux, combinational during the access phase
	always_comb
	begin
		prdata = '0;
		if (acc && !pwrite)
		begin
			case (paddr)
				usfb_pkg::PEER_CFG: prdata = {14'h0, cfg_r};
				usfb_pkg::PEER_RX: prdata = {19'h0, fe_r, pe_r, tx_left_r != 4'h0, rx_valid_r, rx_data_r};
				default: prdata = '0;
			endcase
		end
	end
endmodule

// ===== tb/usfb_properties.sv
// link timing checks for the serial frame and baud control block
`timescale 1ns/10ps
module usfb_properties
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// link signals
	input wire logic dev_txd,
	input wire logic dev_txd_oe,
	input wire logic peer_txd,
	input wire logic sync_serial_clock,
	input wire logic xck_oe,
	input wire logic line_tx
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// the bench runs a divider of 3, so an asynchronous bit lasts four clocks and a synchronous bit eight
	reset_xck_a: assert property ($past(sys_rst) |-> !sync_serial_clock && !xck_oe)
		else $error("clock pin not parked after reset");
	start_width_a: assert property ($fell(line_tx) |-> (!line_tx) [*4])
		else $error("transmit low bit shorter than four clocks");
	high_width_a: assert property ($rose(line_tx) |-> line_tx [*4])
		else $error("transmit high bit shorter than four clocks");
	stop_gap_a: assert property ($fell(line_tx) |-> $past(line_tx, 1) && $past(line_tx, 4))
		else $error("start bit without a full stop bit before it");
	xck_spacing_a: assert property (xck_oe && $changed(sync_serial_clock) |=> $stable(sync_serial_clock) [*3])
		else $error("sync clock toggled before a full tick");
	sync_edge_a: assert property (xck_oe && dev_txd_oe && $changed(dev_txd) |-> $rose(sync_serial_clock))
		else $error("sync data changed off the rising clock");
	peer_width_a: assert property ($fell(peer_txd) |-> (!peer_txd) [*4])
		else $error("peer low bit shorter than four clocks");
	peer_gap_a: assert property ($fell(peer_txd) |-> $past(peer_txd, 4))
		else $error("peer start bit without stop bit before it");
endmodule

// ===== tb/usart_frame_and_baud_control_test.sv
// self-checking bench: device end and peer joined over the serial link
`timescale 1ns/10ps
module usart_frame_and_baud_control_test;
	logic clk = 1'b0; // system clock
	logic sys_rst = 1'b1; // synchronous reset
	// cpu i/o port
	logic [5:0] io_addr = 6'h00;
	logic io_we = 1'b0;
	logic io_re = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] io_rdata;
	logic gie = 1'b0; // global interrupt flag
	logic irq;
	logic port_rx_level;
	// apb master toward the peer
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr; // peer error response
	logic perr; // error response taken with the last apb answer
	int fail_count = 0;
	int num_checks = 0;
	logic [7:0] d8; // scratch read data
	logic [31:0] d32;
	usfb_link_if usfb_link_if_i ();
	usfb_device usfb_device_i (.clk(clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_we(io_we), .io_re(io_re),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_status_word_gie(gie), .irq_buffer_empty(irq),
		.port_tx_level(1'b1), .port_tx_oe(1'b0), .port_rx_level(port_rx_level), .link(usfb_link_if_i.device));
	usfb_peer usfb_peer_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(usfb_link_if_i.peer));
	usfb_properties usfb_properties_i (.clk(clk), .sys_rst(sys_rst), .dev_txd(usfb_link_if_i.dev_txd),
		.dev_txd_oe(usfb_link_if_i.dev_txd_oe), .peer_txd(usfb_link_if_i.peer_txd), .sync_serial_clock(usfb_link_if_i.sync_serial_clock),
		.xck_oe(usfb_link_if_i.xck_oe), .line_tx(usfb_link_if_i.line_tx));
	always #2.5 clk = ~clk;
	// compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one i/o write, strobe for one cycle
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_we <= 1'b1;
		@(posedge clk);
		io_we <= 1'b0;
	endtask
	// one i/o read, data valid the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_re <= 1'b1;
		@(posedge clk);
		io_re <= 1'b0;
		#1 d = io_rdata;
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			chk("pready", 32'h1, 32'h0);
			results();
		end
	endtask
	// link signal picker
	function automatic logic sig(input int s);
		case (s)
			0: sig = usfb_link_if_i.line_tx;
			1: sig = usfb_link_if_i.peer_txd;
			2: sig = usfb_link_if_i.dev_txd_oe;
			3: sig = usfb_link_if_i.sync_serial_clock;
			default: sig = usfb_link_if_i.xck_oe;
		endcase
	endfunction
	// bounded wait for a link level
	task automatic wait_for(input int s, input logic lvl, output int n);
		n = 0;
		while (sig(s) !== lvl && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
		begin
			chk("wait", 32'h1, 32'h0);
			results();
		end
	endtask
	// bounded poll of one status bit
	task automatic poll(input int b);
		int n;
		n = 0;
		d8 = 8'h00;
		while (d8[b] !== 1'b1 && n < 300)
		begin
			rd(6'h0b, d8);
			n++;
		end
		if (n >= 300)
		begin
			chk("poll", 32'h1, 32'h0);
			results();
		end
	endtask
	// wait for transmit complete, then clear it
	task automatic drain();
		poll(6);
		wr(6'h0b, 8'h40);
	endtask
	// peer receive, polled until valid
	task automatic peer_get(output logic [31:0] r);
		int n;
		n = 0;
		r = 32'h0;
		while (r[9] !== 1'b1 && n < 200)
		begin
			apb(1'b0, 8'h08, 32'h0, r);
			n++;
		end
		chk("peer valid", 32'h1, r[9]);
		if (n >= 200)
			results();
	endtask
	// same frame format on both ends, divider 3
	task automatic cfg(input logic [2:0] sz, input logic [1:0] pm, input logic st, input logic tx9);
		wr(6'h0a, {3'b000, 1'b1, 1'b1, sz[2], 1'b0, tx9});
		wr(6'h20, {1'b1, 1'b0, pm, st, sz[1:0], 1'b0});
		apb(1'b1, 8'h00, {14'h0, st, pm, sz, 12'h003}, d32);
	endtask
	// reset values and the shared location
	task automatic t_regs();
		rd(6'h0a, d8);
		chk("ctrl_b", 32'h00, d8);
		rd(6'h0b, d8);
		chk("status", 32'h20, d8);
		rd(6'h20, d8);
		chk("baud hi", 32'h00, d8);
		rd(6'h20, d8);
		chk("ctrl_c", 32'h86, d8);
		chk("irq rst", 32'h0, irq);
		wr(6'h20, 8'h07);
		rd(6'h20, d8);
		chk("baud hi wr", 32'h07, d8);
		rd(6'h20, d8);
		chk("ctrl_c kept", 32'h86, d8);
		wr(6'h20, 8'h00);
		wr(6'h09, 8'h03);
		rd(6'h09, d8);
		chk("baud lo", 32'h03, d8);
		$display("t_regs done");
	endtask
	// buffer-empty interrupt gating
	task automatic t_irq();
		cfg(3'd3, 2'd0, 1'b0, 1'b0);
		wr(6'h0a, 8'h38);
		chk("irq no gie", 32'h0, irq);
		gie <= 1'b1;
		@(posedge clk);
		#1;
		chk("irq on", 32'h1, irq);
		wr(6'h0c, 8'h00);
		#1;
		chk("irq full", 32'h0, irq);
		drain();
		wr(6'h0a, 8'h18);
		#1;
		chk("irq disabled", 32'h0, irq);
		apb(1'b0, 8'h08, 32'h0, d32);
		chk("peer slverr ok", 32'h0, perr);
		apb(1'b0, 8'h0c, 32'h0, d32);
		chk("peer slverr bad", 32'h1, perr);
		$display("t_irq done");
	endtask
	// back-to-back frames, start-to-start spacing
	task automatic t_period(input logic [2:0] sz, input logic [1:0] pm, input logic st, input int bits);
		int n;
		realtime t1;
		cfg(sz, pm, st, 1'b0);
		wr(6'h0c, 8'h00);
		wait_for(0, 1'b0, n);
		t1 = $realtime;
		rd(6'h0b, d8);
		chk("empty", 32'h20, d8 & 8'h20);
		wr(6'h0c, 8'h00);
		wait_for(0, 1'b1, n);
		wait_for(0, 1'b0, n);
		chk("period", bits * 4, int'(($realtime - t1) / 5.0));
		drain();
		apb(1'b0, 8'h08, 32'h0, d32);
		$display("t_period done");
	endtask
	// wire order and parity bit, then peer receive
	task automatic t_bits(input logic [1:0] pm, input logic par);
		int n;
		logic [10:0] f;
		cfg(3'd3, pm, 1'b0, 1'b0);
		wr(6'h0c, 8'h5b);
		wait_for(0, 1'b0, n);
		@(posedge clk);
		for (int i = 0; i < 11; i++)
		begin
			f[i] = sig(0);
			repeat (4) @(posedge clk);
		end
		chk("frame", {21'h0, 1'b1, par, 8'h5b, 1'b0}, f);
		peer_get(d32);
		chk("peer rx", 32'h25b, d32 & 32'h1bff);
		drain();
		$display("t_bits done");
	endtask
	// disable while sending: pin held until drained
	task automatic t_txoff();
		int n;
		cfg(3'd3, 2'd0, 1'b0, 1'b0);
		wr(6'h0c, 8'h33);
		wr(6'h0a, 8'h10);
		#1;
		chk("oe held", 32'h1, sig(2));
		wait_for(2, 1'b0, n);
		chk("oe long", 32'h1, n >= 30);
		peer_get(d32);
		chk("peer rx", 32'h233, d32 & 32'h1bff);
		drain();
		$display("t_txoff done");
	endtask
	// nine-bit characters both ways
	task automatic t_ninth();
		cfg(3'd7, 2'd0, 1'b0, 1'b1);
		wr(6'h0c, 8'h55);
		peer_get(d32);
		chk("peer ninth", 32'h355, d32 & 32'h1bff);
		drain();
		apb(1'b1, 8'h04, 32'h1a5, d32);
		poll(7);
		rd(6'h0a, d8);
		chk("rx ninth", 32'h1, d8[1]);
		rd(6'h0c, d8);
		chk("rx low", 32'ha5, d8);
		$display("t_ninth done");
	endtask
	// parity mismatch, pin takeover, flush on disable
	task automatic t_rx();
		int n;
		cfg(3'd3, 2'd2, 1'b0, 1'b0);
		apb(1'b1, 8'h00, {14'h0, 1'b0, 2'd3, 3'd3, 12'h003}, d32);
		apb(1'b1, 8'h04, 32'h05b, d32);
		wait_for(1, 1'b0, n);
		chk("rx pin owned", 32'h1, port_rx_level);
		poll(7);
		chk("rx errors", 32'h84, d8 & 8'h9c);
		wr(6'h0a, 8'h08);
		rd(6'h0b, d8);
		chk("flushed", 32'h00, d8 & 8'h9c);
		apb(1'b1, 8'h04, 32'h05b, d32);
		wait_for(1, 1'b0, n);
		chk("rx pin port", 32'h0, port_rx_level);
		wait_for(1, 1'b1, n);
		$display("t_rx done");
	endtask
	// synchronous mode drives the clock pin
	task automatic t_sync();
		int n;
		wr(6'h20, 8'hc6);
		wr(6'h0c, 8'h0f);
		chk("xck oe", 32'h1, sig(4));
		wait_for(3, ~sig(3), n);
		chk("xck runs", 32'h1, n <= 8);
		drain();
		wr(6'h20, 8'h86);
		#1;
		chk("xck off", 32'h0, sig(4));
		$display("t_sync done");
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_irq();
		t_period(3'd0, 2'd0, 1'b0, 7);
		t_period(3'd1, 2'd2, 1'b1, 10);
		t_period(3'd2, 2'd3, 1'b1, 11);
		t_period(3'd3, 2'd0, 1'b0, 10);
		t_period(3'd7, 2'd0, 1'b1, 12);
		t_period(3'd4, 2'd2, 1'b0, 11);
		t_bits(2'd2, 1'b1);
		t_bits(2'd3, 1'b0);
		t_txoff();
		t_ninth();
		t_rx();
		t_sync();
		results();
	end
endmodule
